// >>> inc/core_boot_pkg.sv
// constants for the boot, password and return stack control block
package core_boot_pkg;
    localparam int DATA_W = 16;
    localparam int ACC_COUNT = 16;
    localparam int PTR_COUNT = 3;
    localparam int STACK_DEPTH = 16;
    localparam logic [3:0] STACK_PTR_RESET = 4'hf;
    localparam logic [15:0] ROM_START = 16'h8000;
    localparam logic [15:0] APP_START = 16'h0000;
    localparam int FLASH_WORDS = 32768;
    localparam int SRAM_WORDS = 1024;
    localparam int ROM_WORDS = 4096;
    localparam logic [15:0] PWD_FIRST = 16'h0010;
    localparam logic [15:0] PWD_LAST = 16'h001f;
    localparam int PWD_WORDS = 16;
    localparam logic [15:0] PWD_ALL_ONES = 16'hffff;
    localparam logic [15:0] PWD_ALL_ZERO = 16'h0000;
    localparam logic [1:0] PSS_JTAG = 2'h0;
    localparam logic [1:0] PSS_I2C = 2'h1;
    localparam logic [2:0] PERIPH_MODULE_LAST = 3'h5;
    localparam int CLK_MHZ = 100;
    localparam int CLK_ENABLE_DELAY_US = 1000;
    localparam int CLK_ENABLE_CYCLES = CLK_ENABLE_DELAY_US * CLK_MHZ;
    localparam int INSTR_CLK_MHZ = 10;
    localparam int INSTR_DIV = CLK_MHZ / INSTR_CLK_MHZ;
    // stack operation codes
    typedef enum logic [2:0] {
        STK_NONE = 3'h0,
        STK_CALL = 3'h1,
        STK_PUSH = 3'h2,
        STK_INT = 3'h3,
        STK_RET = 3'h4,
        STK_INTERRUPT_RETURN_OP = 3'h5,
        STK_POP = 3'h6,
        STK_STACK_POP_VARIANT_OP = 3'h7
    } stack_op_type;
endpackage

// >>> verilog/core_boot_password_stack.sv
// boot sequencing, password lock, loader select and hardware return stack
`timescale 1ns/1ps

// Function
// - fetch and execute in one cycle
// - sixteen accumulators, any register with active
// - three data pointers with auto step
// - fixed sixteen-bit instruction words
// - separate program, data and register spaces
// - flash, SRAM, ROM sized in words
// - utility ROM starts at 8000h
// - every reset starts execution in ROM
// - password is words 0010h to 001Fh
// - lock resets set; blank passwords need none
// - lock clear grants full utility access
// - mass erase leaves password all ones
// - sixteen by sixteen return stack
// - stack pointer resets to 0Fh
// - push: increment pointer, then write
// - pop: read entry, then decrement
// - source select 00 JTAG, 01 I2C
// - instruction clock gated until brownout plus 1ms
// - peripheral modules zero to five decoded
// - external low reset restarts at 8000h
module core_boot_password_stack
    import core_boot_pkg::*;
#(
    parameter int CLK_DELAY_CYCLES = CLK_ENABLE_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clkEnable,
    input wire logic extReset_n,
    // supply monitor
    input wire logic aboveBrownout,
    // password words loaded from flash (one per cycle, index 0..15)
    input wire logic pwdLoadValid,
    input wire logic [3:0] pwdLoadIndex,
    input wire logic [15:0] pwdLoadWord,
    input wire logic massErase,
    // programmer password entry, one word per cycle
    input wire logic keyValid,
    input wire logic [3:0] keyIndex,
    input wire logic [15:0] keyWord,
    // lock control
    input wire logic lockClear,
    input wire logic lockSet,
    // loader source
    input wire logic [1:0] programming_source_select,
    // stack
    input wire stack_op_type stackOp,
    input wire logic [15:0] stackWriteData,
    // peripheral register address
    input wire logic [2:0] regModule,
    input wire logic regSystem,
    // status
    output logic password_lock_bit,
    output logic utilityAccess,
    output logic jtagLoaderSel,
    output logic i2cLoaderSel,
    output logic [15:0] programCounter,
    output logic [3:0] stack_pointer,
    output logic [15:0] stackReadData,
    output logic instruction_clock,
    output logic instrClockEnabled,
    output logic [5:0] periphModuleSel,
    output logic systemRegSel
);

    // power-up clock gating states
    typedef enum logic [2:0] {
        PWR_BROWNOUT = 3'b001,
        PWR_SETTLE = 3'b010,
        PWR_RUN = 3'b100
    } power_state_type;

    // the core datapath lives elsewhere; this block only carries its control.
    // the instruction word is a fixed 16 bits, so the stack, the program counter
    // and the password words all share the one DATA_W width.
    // accumulators and data pointers sit in the core; their counts are kept in
    // the package so that both sides agree on the sizes.
    // flash, sram and rom sizes are package constants; the rom base is where
    // every reset lands, so the program counter reset value must match it.
    power_state_type powerState_reg, powerState_next;
    // wide enough for a full 1ms at the system clock, with room to spare
    logic [31:0] settleCount_reg;
    logic [3:0] divCount_reg;
    logic [15:0] pwdStore_reg [PWD_WORDS];
    logic [PWD_WORDS-1:0] pwdOnes_reg, pwdZero_reg, keyMatch_reg;
    // sixteen entries of sixteen bits, addressed by the stack pointer
    logic [15:0] stackMem_reg [STACK_DEPTH];
    logic extResetSeen_reg;

    wire logic pwdBlank;
    wire logic keyAllMatch;
    wire logic isPush;
    wire logic isPop;
    wire logic [3:0] spInc;
    wire logic settleDone;
    wire logic [31:0] settleLast;

    // blank passwords (all ones or all zeros) need no key
    assign pwdBlank = (&pwdOnes_reg) | (&pwdZero_reg);
    assign keyAllMatch = &keyMatch_reg;
    assign isPush = (stackOp == STK_CALL) | (stackOp == STK_PUSH) | (stackOp == STK_INT);
    assign isPop = (stackOp == STK_RET) | (stackOp == STK_INTERRUPT_RETURN_OP) | (stackOp == STK_POP)
        | (stackOp == STK_STACK_POP_VARIANT_OP);
    assign spInc = stack_pointer + 4'h1;
    assign settleLast = 32'(CLK_DELAY_CYCLES - 1);
    assign settleDone = settleCount_reg >= settleLast;

    // password store, per word
    // a load while mass erase is active is dropped: erase wins, so a
    // half-written key can never leave the part locked with unknown words.
    // key matches are only flags; the stored words never leave the block,
    // which keeps the key from being read back through the status pins.
    genvar gi;
    generate
        for (gi = 0; gi < PWD_WORDS; gi++) begin : g_pwd
            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    pwdStore_reg[gi] <= PWD_ALL_ONES;
                    pwdOnes_reg[gi] <= 1'b1;
                    pwdZero_reg[gi] <= 1'b0;
                    keyMatch_reg[gi] <= 1'b0;
                end else if (clkEnable) begin
                    if (massErase) begin
                        pwdStore_reg[gi] <= PWD_ALL_ONES;
                        pwdOnes_reg[gi] <= 1'b1;
                        pwdZero_reg[gi] <= 1'b0;
                    end else if (pwdLoadValid && pwdLoadIndex == 4'(gi)) begin
                        pwdStore_reg[gi] <= pwdLoadWord;
                        pwdOnes_reg[gi] <= (pwdLoadWord == PWD_ALL_ONES);
                        pwdZero_reg[gi] <= (pwdLoadWord == PWD_ALL_ZERO);
                    end
                    if (!extReset_n) begin
                        keyMatch_reg[gi] <= 1'b0;
                    end else if (keyValid && keyIndex == 4'(gi)) begin
                        keyMatch_reg[gi] <= (keyWord == pwdStore_reg[gi]);
                    end
                end
            end
        end
    endgenerate

    // lock bit and access grant; external reset relocks
    // lockSet wins over lockClear so a racing request errs on the safe side.
    // access is registered, so it trails the lock and match flops by a cycle;
    // a user must allow two cycles from a strobe before relying on it.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            password_lock_bit <= 1'b1;
            utilityAccess <= 1'b0;
        end else if (clkEnable) begin
            if (!extReset_n || lockSet) begin
                password_lock_bit <= 1'b1;
            end else if (lockClear) begin
                password_lock_bit <= 1'b0;
            end
            utilityAccess <= !password_lock_bit || pwdBlank || keyAllMatch;
        end
    end

    // loader select decode
    // encodings other than jtag and i2c select no loader at all
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            jtagLoaderSel <= 1'b1;
            i2cLoaderSel <= 1'b0;
        end else if (clkEnable) begin
            jtagLoaderSel <= (programming_source_select == PSS_JTAG);
            i2cLoaderSel <= (programming_source_select == PSS_I2C);
        end
    end

    // stack pointer and program counter; push writes at the new pointer
    // the pointer wraps silently at both ends, as the hardware stack has no
    // overflow flag; deep nesting simply overwrites the oldest entry.
    // stack operations outside run state are ignored so that a brownout
    // cannot leave a half-done push behind.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            stack_pointer <= STACK_PTR_RESET;
            programCounter <= ROM_START;
            stackReadData <= 16'h0000;
            extResetSeen_reg <= 1'b0;
        end else if (clkEnable) begin
            extResetSeen_reg <= !extReset_n;
            if (!extReset_n) begin
                stack_pointer <= STACK_PTR_RESET;
                programCounter <= ROM_START;
            end else if (powerState_reg == PWR_RUN) begin
                // one step per cycle, no pipeline
                programCounter <= programCounter + 16'h0001;
                if (isPush) begin
                    stack_pointer <= spInc;
                end else if (isPop) begin
                    stackReadData <= stackMem_reg[stack_pointer];
                    stack_pointer <= stack_pointer - 4'h1;
                end
            end
        end
    end

    // stack storage has no reset; contents are undefined until pushed
    // no reset here keeps the array as plain memory rather than flops
    always_ff @(posedge sys_clk) begin
        if (clkEnable && extReset_n && powerState_reg == PWR_RUN && isPush) begin
            stackMem_reg[spInc] <= stackWriteData;
        end
    end

    // power-up sequence: held until supply is good, then settle delay
    // a dip below threshold during the settle restarts the whole wait,
    // so a slowly rising supply cannot start the core early.
    // the delay is a parameter; a bench may shorten it to save run time.
    always_comb begin
        powerState_next = powerState_reg;
        case (powerState_reg)
            PWR_BROWNOUT: if (aboveBrownout) powerState_next = PWR_SETTLE;
            PWR_SETTLE: begin
                if (!aboveBrownout) begin
                    powerState_next = PWR_BROWNOUT;
                end else if (settleDone) begin
                    powerState_next = PWR_RUN;
                end
            end
            PWR_RUN: if (!aboveBrownout) powerState_next = PWR_BROWNOUT;
            default: powerState_next = PWR_BROWNOUT;
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            powerState_reg <= PWR_BROWNOUT;
            settleCount_reg <= 32'h0000_0000;
        end else if (clkEnable) begin
            powerState_reg <= powerState_next;
            settleCount_reg <= (powerState_reg == PWR_SETTLE) ? settleCount_reg + 32'h0000_0001 : 32'h0000_0000;
        end
    end

    // instruction clock divider, gated off outside run
    // the divided clock is a plain registered level, not a clock net;
    // it starts low on entry to run so the first high phase is full width.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            divCount_reg <= 4'h0;
            instruction_clock <= 1'b0;
            instrClockEnabled <= 1'b0;
        end else if (clkEnable) begin
            instrClockEnabled <= (powerState_reg == PWR_RUN);
            if (powerState_reg != PWR_RUN) begin
                divCount_reg <= 4'h0;
                instruction_clock <= 1'b0;
            end else if (divCount_reg == 4'(INSTR_DIV / 2 - 1)) begin
                divCount_reg <= 4'h0;
                instruction_clock <= !instruction_clock;
            end else begin
                divCount_reg <= divCount_reg + 4'h1;
            end
        end
    end

    // register-space decode; system group separate from modules 0..5
    // module codes six and seven select nothing
    generate
        for (gi = 0; gi < 6; gi++) begin : g_mod
            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    periphModuleSel[gi] <= 1'b0;
                end else if (clkEnable) begin
                    periphModuleSel[gi] <= !regSystem && regModule == 3'(gi);
                end
            end
        end
    endgenerate

    // system group select; kept apart from the peripheral modules
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            systemRegSel <= 1'b0;
        end else if (clkEnable) begin
            systemRegSel <= regSystem;
        end
    end

endmodule

// >>> sim/core_boot_password_stack_properties.sv
// timing checks for the boot, lock and stack block
`timescale 1ns/1ps
module core_boot_password_stack_properties
    import core_boot_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clkEnable,
    input wire logic extReset_n,
    input wire logic aboveBrownout,
    // controls
    input wire logic [1:0] programming_source_select,
    input wire stack_op_type stackOp,
    // status
    input wire logic password_lock_bit,
    input wire logic utilityAccess,
    input wire logic jtagLoaderSel,
    input wire logic i2cLoaderSel,
    input wire logic [15:0] programCounter,
    input wire logic [3:0] stack_pointer,
    input wire logic instruction_clock,
    input wire logic instrClockEnabled
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // cycles in which the core really runs
    logic live;
    assign live = clkEnable && extReset_n && aboveBrownout && instrClockEnabled;
    a_push_step: assert property (live && stackOp == STK_PUSH |=> stack_pointer == $past(stack_pointer) + 4'h1)
        else $error("push did not raise the pointer");
    a_pop_step: assert property (live && stackOp == STK_POP |=> stack_pointer == $past(stack_pointer) - 4'h1)
        else $error("pop did not lower the pointer");
    a_pc_step: assert property (live |=> programCounter == $past(programCounter) + 16'h1)
        else $error("program counter did not advance");
    a_ext_restart: assert property (clkEnable && !extReset_n |=> password_lock_bit && stack_pointer == STACK_PTR_RESET
        && programCounter == ROM_START)
        else $error("external reset did not restart");
    a_jtag_pick: assert property (clkEnable && programming_source_select == PSS_JTAG |=> jtagLoaderSel && !i2cLoaderSel)
        else $error("jtag loader not selected");
    a_i2c_pick: assert property (clkEnable && programming_source_select == PSS_I2C |=> i2cLoaderSel && !jtagLoaderSel)
        else $error("i2c loader not selected");
    a_open_access: assert property (clkEnable && extReset_n && !password_lock_bit |=> utilityAccess)
        else $error("clear lock did not open utilities");
    a_clock_gated: assert property ((clkEnable && !aboveBrownout)[*3] |-> !instrClockEnabled && !instruction_clock)
        else $error("clock ran below threshold");
endmodule
bind core_boot_password_stack core_boot_password_stack_properties u_props (.sys_clk, .reset, .clkEnable,
    .extReset_n, .aboveBrownout, .programming_source_select, .stackOp, .password_lock_bit, .utilityAccess,
    .jtagLoaderSel, .i2cLoaderSel, .programCounter, .stack_pointer, .instruction_clock, .instrClockEnabled);

// >>> sim/key_programmer.sv
// programmer model that presents a sixteen word key
`timescale 1ns/1ps
module key_programmer
    import core_boot_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // key words toward the device
    output logic keyValid,
    output logic [3:0] keyIndex,
    output logic [15:0] keyWord
);
    initial begin
        keyValid = 1'b0;
        keyIndex = 4'h0;
        keyWord = 16'h0000;
    end
    // one word per cycle, all sixteen in order
    task automatic send(input logic [15:0] k [PWD_WORDS]);
        for (int i = 0; i < PWD_WORDS; i++) begin
            @(negedge sys_clk);
            keyValid = 1'b1;
            keyIndex = i[3:0];
            keyWord = k[i];
        end
        @(negedge sys_clk);
        keyValid = 1'b0;
        keyWord = ~keyWord; // stale word is not held after release
    endtask
endmodule

// >>> sim/tb_core_boot_password_stack.sv
// self-checking bench for the boot, lock and stack block
`timescale 1ns/1ps
module tb_core_boot_password_stack
    import core_boot_pkg::*;
;
    logic sys_clk = 0, reset = 1, clkEnable = 1, extReset_n = 1, aboveBrownout = 0;
    logic pwdLoadValid = 0, massErase = 0, lockClear = 0, lockSet = 0, regSystem = 0, wasPop = 0;
    logic [3:0] pwdLoadIndex = 0;
    logic [15:0] pwdLoadWord = 0, stackWriteData = 0;
    logic [1:0] programming_source_select = 0;
    logic [2:0] regModule = 0;
    stack_op_type stackOp = STK_NONE;
    logic keyValid, utilityAccess, password_lock_bit, jtagLoaderSel, i2cLoaderSel;
    logic instruction_clock, instrClockEnabled, systemRegSel;
    logic [3:0] keyIndex, stack_pointer;
    logic [15:0] keyWord, programCounter, stackReadData, pc;
    logic [5:0] periphModuleSel;
    logic [15:0] pw [PWD_WORDS];
    logic [15:0] k [PWD_WORDS];
    logic [15:0] v [3];
    logic [15:0] expq [$];
    int errors = 0, tests_run = 0, n;
    initial forever #5 sys_clk = ~sys_clk;
    core_boot_password_stack #(.CLK_DELAY_CYCLES(20)) u_core_boot_password_stack (.sys_clk, .reset, .clkEnable,
        .extReset_n, .aboveBrownout, .pwdLoadValid, .pwdLoadIndex, .pwdLoadWord, .massErase, .keyValid, .keyIndex,
        .keyWord, .lockClear, .lockSet, .programming_source_select, .stackOp, .stackWriteData, .regModule,
        .regSystem, .password_lock_bit, .utilityAccess, .jtagLoaderSel, .i2cLoaderSel, .programCounter,
        .stack_pointer, .stackReadData, .instruction_clock, .instrClockEnabled, .periphModuleSel, .systemRegSel);
    key_programmer u_key_programmer (.sys_clk, .keyValid, .keyIndex, .keyWord);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic tick(input int c);
        repeat (c) @(negedge sys_clk);
    endtask
    // popped words are registered on the same edge that takes the pop
    always @(posedge sys_clk) wasPop <= (stackOp == STK_POP) && !reset;
    always @(negedge sys_clk) if (wasPop) check(stackReadData, expq.pop_front());
    initial begin
        n = $urandom(60410);
        tick(20);
        reset = 0;
        tick(5);
        check(stack_pointer, STACK_PTR_RESET);
        check(password_lock_bit, 1'b1);
        check(instrClockEnabled, 1'b0);
        check(utilityAccess, 1'b1);
        aboveBrownout = 1;
        for (n = 0; n < 200 && instrClockEnabled !== 1'b1; n++) tick(1);
        check(n >= 20 && n < 200, 1'b1);
        check(programCounter >= ROM_START, 1'b1);
        pc = programCounter;
        tick(4);
        check(programCounter, pc + 16'h4);
        clkEnable = 0;
        pc = programCounter;
        tick(3);
        check(programCounter, pc);
        clkEnable = 1;
        // random password that is neither blank pattern
        for (int i = 0; i < PWD_WORDS; i++) begin
            pw[i] = $urandom;
            pw[i][0] = (i == 1);
            k[i] = pw[i];
            pwdLoadValid = 1;
            pwdLoadIndex = i[3:0];
            pwdLoadWord = pw[i];
            tick(1);
        end
        pwdLoadValid = 0;
        pwdLoadWord = ~pwdLoadWord;
        tick(3);
        check(utilityAccess, 1'b0);
        k[15] = ~k[15];
        u_key_programmer.send(k);
        tick(3);
        check(utilityAccess, 1'b0);
        u_key_programmer.send(pw);
        tick(3);
        check(utilityAccess, 1'b1);
        extReset_n = 0;
        tick(1);
        extReset_n = 1;
        tick(3);
        check(utilityAccess, 1'b0);
        check(programCounter, ROM_START + 16'h3);
        lockClear = 1;
        tick(1);
        lockClear = 0;
        tick(3);
        check(utilityAccess, 1'b1);
        lockSet = 1;
        tick(1);
        lockSet = 0;
        tick(3);
        check(utilityAccess, 1'b0);
        massErase = 1;
        tick(1);
        massErase = 0;
        tick(3);
        check(utilityAccess, 1'b1);
        for (int p = 0; p < 2; p++) begin
            programming_source_select = p[1:0];
            tick(2);
            check(jtagLoaderSel, p == 0);
            check(i2cLoaderSel, p == 1);
        end
        for (int m = 0; m < 6; m++) begin
            regModule = m[2:0];
            tick(2);
            check(periphModuleSel, 6'h1 << m);
        end
        // three pushes then three pops, back to back
        for (int i = 0; i < 3; i++) begin
            stackOp = STK_PUSH;
            v[i] = $urandom;
            stackWriteData = v[i];
            tick(1);
        end
        stackOp = STK_NONE;
        tick(1);
        check(stack_pointer, 4'h2);
        for (int i = 2; i >= 0; i--) begin
            stackOp = STK_POP;
            expq.push_back(v[i]);
            tick(1);
        end
        stackOp = STK_NONE;
        tick(2);
        check(stack_pointer, STACK_PTR_RESET);
        check(expq.size(), 16'h0);
        aboveBrownout = 0;
        tick(3);
        check(instrClockEnabled, 1'b0);
        check(instruction_clock, 1'b0);
        end_of_test();
    end
endmodule
